// [core/bit_field_move_unit.sv]
// Overview of operation
// - Fields of 1 to 32 bits; select bit picks setting zero or one.
// - Only the set-field instruction loads settings; moves use the latest values.
// - Register stores take the field from the source register's low bits.
// - All field move addresses are bit addresses; fields start anywhere.
// - Post-increment store adds field length to destination pointer afterwards.
// - Pre-decrement store subtracts length first, writes there, keeps reduced pointer.
// - Offset store targets register plus sign-extended 16-bit offset; register unchanged.
// - Absolute store: first extension word low address half, second high half.
// - Absolute address used directly; no register part, no pointer update.
// - Indirect load right-justifies field, sign or zero extends to 32 bits.
// - Loads set N and Z from the extended value; carry untouched.
// - Memory-to-memory reads at source pointer, writes at destination pointer.
// - Both operands come from one file picked by the file-select bit.
// - Aligned pre-decrement store takes 6 states for 16 bits, 8 for 32.
// - Aligned 32-bit indirect load takes 8 states.
// - Aligned 32-bit memory-to-memory move takes 11 states.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bit_field_move_unit (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire bit_field_move_pkg::wb_req_s  wb_i,
  output var  bit_field_move_pkg::wb_rsp_s  wb_o,
  output var  bit_field_move_pkg::mem_cmd_s mem_o,
  input  wire bit_field_move_pkg::mem_rsp_s mem_i,
  output logic                              busy
);
  typedef enum logic [2:0] {
    S_IDLE, S_RD_SRC, S_EXTRACT, S_RD_DST, S_WR_DST, S_FINISH
  } state_e;

  state_e                    state_q;
  bit_field_move_pkg::mode_e mode_q;
  bit_field_move_pkg::mode_e dec_mode;
  logic [31:0] regs_q [0:31];
  logic [1:0][4:0] size_q;
  logic [1:0]  ex_q;
  logic [31:0] ext_q;
  logic [4:0]  rd_idx_q;
  logic [31:0] src_ptr_q;
  logic [31:0] dst_ptr_q;
  logic [31:0] new_ptr_q;
  logic [31:0] wr_data_q;
  logic [5:0]  len_q;
  logic        sign_q;
  logic [1:0]  widx_q;
  logic [1:0]  nw_q;
  logic [1:0]  nw_dst_q;
  logic [47:0] rbuf_q;
  logic [15:0] old_q;
  logic [7:0]  cyc_cnt_q;
  logic [7:0]  min_cyc_q;
  logic        n_q;
  logic        c_q;
  logic        z_q;
  logic        v_q;
  logic        illegal_q;

  logic        wb_req;
  logic        start;
  logic [15:0] op;
  logic [4:0]  dec_si;
  logic [4:0]  dec_rd;
  logic [4:0]  dec_size;
  logic [5:0]  dec_len;
  logic [31:0] dec_src;
  logic [31:0] dec_dst;
  logic [31:0] dec_new;
  logic [6:0]  span_src;
  logic [6:0]  span_dst;
  logic [7:0]  dec_min;
  logic [47:0] ins_mask;
  logic [47:0] ins_data;
  logic [31:0] raw_field;
  logic [31:0] ext_field;
  logic [15:0] mask_slice;
  logic [15:0] data_slice;
  logic        last_word;
  logic        done;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  // New bus request only while no answer is outstanding
  assign wb_req = wb_i.cyc && wb_i.stb && !wb_o.ack;
  assign op     = wb_i.dat[15:0];
  assign start  = wb_req && wb_i.we && (wb_i.adr == bit_field_move_pkg::ADDR_OPCODE)
                  && (wb_i.sel[1:0] == 2'b11) && (state_q == S_IDLE);

  // Opcode decode
  always_comb begin
    case (op[15:10])
      bit_field_move_pkg::OPG_ST_IND: dec_mode = bit_field_move_pkg::M_ST_IND;
      bit_field_move_pkg::OPG_ST_INC: dec_mode = bit_field_move_pkg::M_ST_INC;
      bit_field_move_pkg::OPG_ST_DEC: dec_mode = bit_field_move_pkg::M_ST_DEC;
      bit_field_move_pkg::OPG_ST_OFF: dec_mode = bit_field_move_pkg::M_ST_OFF;
      bit_field_move_pkg::OPG_LD_IND: dec_mode = bit_field_move_pkg::M_LD_IND;
      bit_field_move_pkg::OPG_MM_IND: dec_mode = bit_field_move_pkg::M_MM_IND;
      bit_field_move_pkg::OPG_MISC: begin
        if (op[8:5] == bit_field_move_pkg::SUB_ABS) begin
          dec_mode = bit_field_move_pkg::M_ST_ABS;
        end else if (op[8:6] == bit_field_move_pkg::SUB_FSET) begin
          dec_mode = bit_field_move_pkg::M_FSET;
        end else begin
          dec_mode = bit_field_move_pkg::M_ILLEGAL;
        end
      end
      default: dec_mode = bit_field_move_pkg::M_ILLEGAL;
    endcase
  end

  // Operand indices share one file bit; absolute form keeps source in low nibble
  always_comb begin
    dec_rd = {op[4], op[3:0]};
    if (dec_mode == bit_field_move_pkg::M_ST_ABS) begin
      dec_si = {op[4], op[3:0]};
    end else begin
      dec_si = {op[4], op[8:5]};
    end
    dec_size = size_q[op[9]];
    dec_len  = (dec_size == 5'h00) ? 6'd32 : {1'b0, dec_size};
  end

  // Bit addresses for each form
  always_comb begin
    dec_src = regs_q[dec_si];
    dec_dst = regs_q[dec_rd];
    dec_new = regs_q[dec_rd];
    case (dec_mode)
      bit_field_move_pkg::M_ST_INC: dec_new = regs_q[dec_rd] + {26'h0, dec_len};
      bit_field_move_pkg::M_ST_DEC: begin
        dec_dst = regs_q[dec_rd] - {26'h0, dec_len};
        dec_new = dec_dst;
      end
      bit_field_move_pkg::M_ST_OFF: dec_dst = regs_q[dec_rd] + {{16{ext_q[15]}}, ext_q[15:0]};
      bit_field_move_pkg::M_ST_ABS: dec_dst = {ext_q[31:16], ext_q[15:0]};
      default: dec_dst = regs_q[dec_rd];
    endcase
  end

  // Word counts spanned and least busy time for aligned cases
  always_comb begin
    span_src = 7'(({3'h0, dec_src[3:0]} + {1'b0, dec_len}) + 7'd15);
    span_dst = 7'(({3'h0, dec_dst[3:0]} + {1'b0, dec_len}) + 7'd15);
    dec_min  = 8'h00;
    if (dec_mode == bit_field_move_pkg::M_ST_DEC && dec_dst[3:0] == 4'h0) begin
      if (dec_len == 6'd16) begin
        dec_min = bit_field_move_pkg::MS_PREDEC16;
      end else if (dec_len == 6'd32) begin
        dec_min = bit_field_move_pkg::MS_PREDEC32;
      end
    end else if (dec_mode == bit_field_move_pkg::M_LD_IND && dec_src[3:0] == 4'h0
                 && dec_len == 6'd32) begin
      dec_min = bit_field_move_pkg::MS_LOAD32;
    end else if (dec_mode == bit_field_move_pkg::M_MM_IND && dec_src[3:0] == 4'h0
                 && dec_dst[3:0] == 4'h0 && dec_len == 6'd32) begin
      dec_min = bit_field_move_pkg::MS_MEMMEM32;
    end
  end

  field_shifter u_shift (
    .src_off   (src_ptr_q[3:0]),
    .dst_off   (dst_ptr_q[3:0]),
    .len       (len_q),
    .sign_ext  (sign_q),
    .wr_data   (wr_data_q),
    .rd_buf    (rbuf_q),
    .ins_mask  (ins_mask),
    .ins_data  (ins_data),
    .raw_field (raw_field),
    .ext_field (ext_field)
  );

  // Per-word merge; untouched bits come from the word just read
  assign mask_slice = ins_mask[{widx_q, 4'h0} +: 16];
  assign data_slice = ins_data[{widx_q, 4'h0} +: 16];
  assign last_word  = (widx_q == 2'(nw_q - 2'd1));
  // Finish waits out the least time of the aligned cases
  assign done = (state_q == S_FINISH) && (cyc_cnt_q >= min_cyc_q);

  // Sequencer and memory port; valid drops for a cycle after every ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      mode_q    <= bit_field_move_pkg::M_ILLEGAL;
      mem_o     <= '0;
      rd_idx_q  <= 5'h00;
      src_ptr_q <= 32'h0000_0000;
      dst_ptr_q <= 32'h0000_0000;
      new_ptr_q <= 32'h0000_0000;
      wr_data_q <= 32'h0000_0000;
      len_q     <= 6'd32;
      sign_q    <= 1'b0;
      widx_q    <= 2'h0;
      nw_q      <= 2'h1;
      nw_dst_q  <= 2'h1;
      rbuf_q    <= 48'h0000_0000_0000;
      old_q     <= 16'h0000;
      min_cyc_q <= 8'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start && dec_mode != bit_field_move_pkg::M_FSET
              && dec_mode != bit_field_move_pkg::M_ILLEGAL) begin
            mode_q    <= dec_mode;
            rd_idx_q  <= dec_rd;
            src_ptr_q <= dec_src;
            dst_ptr_q <= dec_dst;
            new_ptr_q <= dec_new;
            wr_data_q <= regs_q[dec_si];
            len_q     <= dec_len;
            sign_q    <= ex_q[op[9]];
            min_cyc_q <= dec_min;
            widx_q    <= 2'h0;
            rbuf_q    <= 48'h0000_0000_0000;
            nw_dst_q  <= span_dst[5:4];
            if (dec_mode == bit_field_move_pkg::M_LD_IND
                || dec_mode == bit_field_move_pkg::M_MM_IND) begin
              nw_q    <= span_src[5:4];
              state_q <= S_RD_SRC;
            end else begin
              nw_q    <= span_dst[5:4];
              state_q <= S_RD_DST;
            end
          end
        end
        S_RD_SRC: begin
          if (mem_o.valid && mem_i.ack) begin
            mem_o.valid <= 1'b0;
            rbuf_q[{widx_q, 4'h0} +: 16] <= mem_i.rdata;
            if (last_word) begin
              state_q <= S_EXTRACT;
            end else begin
              widx_q <= widx_q + 2'h1;
            end
          end else if (!mem_o.valid) begin
            mem_o.valid <= 1'b1;
            mem_o.we    <= 1'b0;
            mem_o.addr  <= src_ptr_q[31:4] + {26'h0, widx_q};
          end
        end
        S_EXTRACT: begin
          widx_q <= 2'h0;
          nw_q   <= nw_dst_q;
          if (mode_q == bit_field_move_pkg::M_MM_IND) begin
            wr_data_q <= raw_field;
            state_q   <= S_RD_DST;
          end else begin
            wr_data_q <= ext_field;
            state_q   <= S_FINISH;
          end
        end
        S_RD_DST: begin
          if (mem_o.valid && mem_i.ack) begin
            mem_o.valid <= 1'b0;
            old_q       <= mem_i.rdata;
            state_q     <= S_WR_DST;
          end else if (!mem_o.valid) begin
            mem_o.valid <= 1'b1;
            mem_o.we    <= 1'b0;
            mem_o.addr  <= dst_ptr_q[31:4] + {26'h0, widx_q};
          end
        end
        S_WR_DST: begin
          if (mem_o.valid && mem_i.ack) begin
            mem_o.valid <= 1'b0;
            if (last_word) begin
              state_q <= S_FINISH;
            end else begin
              widx_q  <= widx_q + 2'h1;
              state_q <= S_RD_DST;
            end
          end else if (!mem_o.valid) begin
            mem_o.valid <= 1'b1;
            mem_o.we    <= 1'b1;
            mem_o.wdata <= (old_q & ~mask_slice) | (data_slice & mask_slice);
          end
        end
        S_FINISH: begin
          if (done) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Busy cycle count from the accepting edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_q <= 8'h00;
      busy      <= 1'b0;
    end else if (state_q == S_IDLE) begin
      cyc_cnt_q <= 8'h01;
      busy      <= start && dec_mode != bit_field_move_pkg::M_FSET
                   && dec_mode != bit_field_move_pkg::M_ILLEGAL;
    end else begin
      if (cyc_cnt_q != 8'hFF) begin
        cyc_cnt_q <= cyc_cnt_q + 8'h01;
      end
      busy <= !done;
    end
  end

  // Field settings; nothing but the set-field opcode may touch them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      size_q <= {bit_field_move_pkg::SIZE_RST, bit_field_move_pkg::SIZE_RST};
      ex_q   <= {bit_field_move_pkg::EXT_RST, bit_field_move_pkg::EXT_RST};
    end else if (start && dec_mode == bit_field_move_pkg::M_FSET) begin
      size_q[op[9]] <= op[4:0];
      ex_q[op[9]]   <= op[5];
    end
  end

  // Byte lane mask for bus writes
  assign wmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};

  // Register file; bus writes only while idle, so the sequencer owns it when busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= bit_field_move_pkg::REG_RST;
      end
    end else if (done && mode_q == bit_field_move_pkg::M_LD_IND) begin
      regs_q[rd_idx_q] <= wr_data_q;
    end else if (done && (mode_q == bit_field_move_pkg::M_ST_INC
                          || mode_q == bit_field_move_pkg::M_ST_DEC)) begin
      regs_q[rd_idx_q] <= new_ptr_q;
    end else if (wb_req && wb_i.we && wb_i.adr[7] && state_q == S_IDLE) begin
      regs_q[wb_i.adr[6:2]] <= (regs_q[wb_i.adr[6:2]] & ~wmask) | (wb_i.dat & wmask);
    end
  end

  // Extension words, written by software ahead of the opcode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 32'h0000_0000;
    end else if (wb_req && wb_i.we && wb_i.adr == bit_field_move_pkg::ADDR_EXT
                 && state_q == S_IDLE) begin
      ext_q <= (ext_q & ~wmask) | (wb_i.dat & wmask);
    end
  end

  // Flags: loads set N and Z, carry only by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_q <= 1'b0;
      c_q <= 1'b0;
      z_q <= 1'b0;
      v_q <= 1'b0;
    end else if (done && mode_q == bit_field_move_pkg::M_LD_IND) begin
      n_q <= wr_data_q[31];
      z_q <= (wr_data_q == 32'h0000_0000);
    end else if (wb_req && wb_i.we && wb_i.adr == bit_field_move_pkg::ADDR_STATUS
                 && wb_i.sel[3] && state_q == S_IDLE) begin
      n_q <= wb_i.dat[bit_field_move_pkg::ST_N_BIT];
      c_q <= wb_i.dat[bit_field_move_pkg::ST_C_BIT];
      z_q <= wb_i.dat[bit_field_move_pkg::ST_Z_BIT];
      v_q <= wb_i.dat[bit_field_move_pkg::ST_V_BIT];
    end
  end

  // Illegal marker follows the most recent accepted opcode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else if (start) begin
      illegal_q <= (dec_mode == bit_field_move_pkg::M_ILLEGAL);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_i.adr[7]) begin
      rd_mux = regs_q[wb_i.adr[6:2]];
    end else begin
      case (wb_i.adr)
        bit_field_move_pkg::ADDR_EXT: rd_mux = ext_q;
        bit_field_move_pkg::ADDR_FIELD: begin
          rd_mux[bit_field_move_pkg::FLD_SIZE0_LSB +: 5] = size_q[0];
          rd_mux[bit_field_move_pkg::FLD_EXT0_BIT]       = ex_q[0];
          rd_mux[bit_field_move_pkg::FLD_SIZE1_LSB +: 5] = size_q[1];
          rd_mux[bit_field_move_pkg::FLD_EXT1_BIT]       = ex_q[1];
        end
        bit_field_move_pkg::ADDR_STATUS: begin
          rd_mux[bit_field_move_pkg::ST_BUSY_BIT]    = busy;
          rd_mux[bit_field_move_pkg::ST_ILLEGAL_BIT] = illegal_q;
          rd_mux[bit_field_move_pkg::ST_N_BIT]       = n_q;
          rd_mux[bit_field_move_pkg::ST_C_BIT]       = c_q;
          rd_mux[bit_field_move_pkg::ST_Z_BIT]       = z_q;
          rd_mux[bit_field_move_pkg::ST_V_BIT]       = v_q;
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer one cycle after the request, every offset acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_o <= '0;
    end else begin
      wb_o.ack <= wb_req;
      wb_o.dat <= (wb_req && !wb_i.we) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [pkg/bit_field_move_pkg.sv]
`default_nettype none
package bit_field_move_pkg;

  // Register offsets on the bus (byte addresses)
  localparam logic [7:0] ADDR_OPCODE = 8'h00;
  localparam logic [7:0] ADDR_EXT    = 8'h04;
  localparam logic [7:0] ADDR_FIELD  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_REGS   = 8'h80;

  // Opcode groups, bits 15:10
  localparam logic [5:0] OPG_ST_IND = 6'h20;
  localparam logic [5:0] OPG_ST_INC = 6'h24;
  localparam logic [5:0] OPG_ST_DEC = 6'h28;
  localparam logic [5:0] OPG_ST_OFF = 6'h2C;
  localparam logic [5:0] OPG_LD_IND = 6'h21;
  localparam logic [5:0] OPG_MM_IND = 6'h22;
  localparam logic [5:0] OPG_MISC   = 6'h01;
  // Sub codes inside the misc group
  localparam logic [3:0] SUB_ABS  = 4'hC;
  localparam logic [2:0] SUB_FSET = 3'h5;

  // Field setting register layout
  localparam int FLD_SIZE0_LSB = 0;
  localparam int FLD_EXT0_BIT  = 5;
  localparam int FLD_SIZE1_LSB = 6;
  localparam int FLD_EXT1_BIT  = 11;
  // Status register layout
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_V_BIT       = 28;
  localparam int ST_Z_BIT       = 29;
  localparam int ST_C_BIT       = 30;
  localparam int ST_N_BIT       = 31;

  // Reset values; a size code of zero means a 32-bit field
  localparam logic [4:0]  SIZE_RST = 5'h00;
  localparam logic        EXT_RST  = 1'b0;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;

  // Least busy times, in machine states of one clock each
  localparam logic [7:0] MS_PREDEC16 = 8'h06;
  localparam logic [7:0] MS_PREDEC32 = 8'h08;
  localparam logic [7:0] MS_LOAD32   = 8'h08;
  localparam logic [7:0] MS_MEMMEM32 = 8'h0B;

  typedef enum logic [3:0] {
    M_ST_IND, M_ST_INC, M_ST_DEC, M_ST_OFF, M_ST_ABS,
    M_LD_IND, M_MM_IND, M_FSET, M_ILLEGAL
  } mode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [27:0] addr;
    logic [15:0] wdata;
  } mem_cmd_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mem_rsp_s;

endpackage
`default_nettype wire

// [core/field_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module field_shifter (
  input  wire logic [3:0]  src_off,
  input  wire logic [3:0]  dst_off,
  input  wire logic [5:0]  len,
  input  wire logic        sign_ext,
  input  wire logic [31:0] wr_data,
  input  wire logic [47:0] rd_buf,
  output logic      [47:0] ins_mask,
  output logic      [47:0] ins_data,
  output logic      [31:0] raw_field,
  output logic      [31:0] ext_field
);
  logic [32:0] one_hot;
  logic [31:0] fmask;
  logic [47:0] shifted;
  logic [4:0]  top_bit;

  // Length mask; a 33-bit shift keeps len of 32 legal
  always_comb begin
    one_hot = 33'h1_0000_0000 >> (6'd32 - len);
    fmask   = 32'(one_hot - 33'h1);
    top_bit = 5'(len - 6'd1);
  end

  // Source side: right-justify then extend from the top field bit
  always_comb begin
    shifted   = rd_buf >> src_off;
    raw_field = shifted[31:0] & fmask;
    ext_field = (sign_ext && raw_field[top_bit]) ? (raw_field | ~fmask) : raw_field;
  end

  // Destination side: low bits of the source, placed at the bit offset
  always_comb begin
    ins_mask = {16'h0000, fmask} << dst_off;
    ins_data = {16'h0000, wr_data & fmask} << dst_off;
  end
endmodule
`default_nettype wire

// [verification/bit_field_move_unit_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_field_move_unit_assertions (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire bit_field_move_pkg::wb_req_s  wb_i,
  input wire bit_field_move_pkg::wb_rsp_s  wb_o,
  input wire bit_field_move_pkg::mem_cmd_s mem_o,
  input wire bit_field_move_pkg::mem_rsp_s mem_i,
  input wire logic                         busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        req;
  logic        op_go;
  logic [27:0] rd_addr_q;
  // Fresh opcode write taken while idle
  assign req = wb_i.cyc && wb_i.stb && !wb_o.ack;
  assign op_go = req && wb_i.we && !busy && wb_i.sel[1:0] == 2'b11 &&
                 wb_i.adr == bit_field_move_pkg::ADDR_OPCODE;
  // Last word read back; a write may only land on it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_addr_q <= 28'h000_0000;
    else if (mem_o.valid && mem_i.ack && !mem_o.we) rd_addr_q <= mem_o.addr;
  end
  property p_ack_next; req |=> wb_o.ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; wb_o.ack |=> !wb_o.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_quiet; !wb_o.ack |-> wb_o.dat == 32'h0000_0000; endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
  property p_mem_hold; mem_o.valid && !mem_i.ack |=> mem_o.valid && $stable(mem_o); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
  property p_mem_gap; mem_o.valid && mem_i.ack |=> !mem_o.valid; endproperty
  a_mem_gap: assert property (p_mem_gap) else $error("no gap after memory ack");
  property p_mem_busy; mem_o.valid |-> busy; endproperty
  a_mem_busy: assert property (p_mem_busy) else $error("memory access while idle");
  property p_dec_start;
    op_go && wb_i.dat[15:10] == bit_field_move_pkg::OPG_ST_DEC |=> busy [*4];
  endproperty
  a_dec_start: assert property (p_dec_start) else $error("store not started");
  property p_fset_idle;
    op_go && wb_i.dat[15:10] == bit_field_move_pkg::OPG_MISC &&
      wb_i.dat[8:6] == bit_field_move_pkg::SUB_FSET |=> !busy;
  endproperty
  a_fset_idle: assert property (p_fset_idle) else $error("set-field went busy");
  property p_rmw; mem_o.valid && mem_o.we |-> mem_o.addr == rd_addr_q; endproperty
  a_rmw: assert property (p_rmw) else $error("write without read back");
  c_store: cover property (mem_o.valid && mem_o.we && mem_i.ack);
  c_done: cover property ($fell(busy));
  c_stall: cover property ((mem_o.valid && !mem_i.ack) [*3]);
endmodule
bind bit_field_move_unit bit_field_move_unit_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .wb_i(wb_i), .wb_o(wb_o), .mem_o(mem_o), .mem_i(mem_i), .busy(busy));
`default_nettype wire

// [verification/field_memory_model.sv]
`timescale 1ns/1ps
`default_nettype none
module field_memory_model (
  input  wire logic                         clk,
  input  wire logic                         slow,
  input  wire bit_field_move_pkg::mem_cmd_s cmd,
  output var  bit_field_move_pkg::mem_rsp_s rsp
);
  logic [15:0] mem [logic [27:0]];
  logic [1:0]  wait_q = 2'h0;
  initial rsp = '0;
  // One ack per request; slow mode stalls three cycles first
  always @(posedge clk) begin
    rsp.ack <= 1'b0;
    rsp.rdata <= ~rsp.rdata; // Stale data must not look valid
    if (cmd.valid && !rsp.ack) begin
      if (slow && wait_q != 2'h3) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q <= 2'h0;
        rsp.ack <= 1'b1;
        if (cmd.we) mem[cmd.addr] = cmd.wdata;
        else rsp.rdata <= mem.exists(cmd.addr) ? mem[cmd.addr] : 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/bit_field_move_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_field_move_unit_tb;
  logic                         clk = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         slow = 1'b0;
  bit_field_move_pkg::wb_req_s  wb_i = '0;
  bit_field_move_pkg::wb_rsp_s  wb_o;
  bit_field_move_pkg::mem_cmd_s mem_o;
  bit_field_move_pkg::mem_rsp_s mem_i;
  logic                         busy;
  logic [31:0]                  q;
  int                           error_cnt = 0;
  int                           n_checks = 0;
  int                           ticks = 0;
  int                           blen = 0;
  bit_field_move_unit dut (.clk(clk), .rst_n(rst_n), .wb_i(wb_i), .wb_o(wb_o),
                           .mem_o(mem_o), .mem_i(mem_i), .busy(busy));
  field_memory_model u_mem (.clk(clk), .slow(slow), .cmd(mem_o), .rsp(mem_i));
  always #10 clk = ~clk;
  // Watchdog and busy length meter
  always @(posedge clk) begin
    ticks++;
    if (busy === 1'b1) blen++;
    if (ticks == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
    @(posedge clk);
    while (wb_o.ack !== 1'b1) @(posedge clk);
    q = wb_o.dat;
    wb_i <= '0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] ra(input int i);
    return bit_field_move_pkg::ADDR_REGS + 8'(4 * i);
  endfunction
  task automatic rchk(input int i, input logic [31:0] e);
    wb(1'b0, ra(i), 32'h0000_0000);
    chk("register", e, q);
  endtask
  task automatic poke(input logic [15:0] a, input logic [15:0] d);
    u_mem.mem[{12'h000, a}] = d;
  endtask
  task automatic mchk(input logic [15:0] a, input logic [15:0] e);
    chk("memory word", {16'h0000, e}, {16'h0000, u_mem.mem[{12'h000, a}]});
  endtask
  task automatic fset(input logic f, input logic ex, input logic [4:0] sz);
    wb(1'b1, bit_field_move_pkg::ADDR_OPCODE, {16'h0000, 6'h01, f, 3'h5, ex, sz});
  endtask
  // Start a move and wait for it; busy must last at least min cycles
  task automatic run(input logic [15:0] op, input int min);
    blen = 0;
    wb(1'b1, bit_field_move_pkg::ADDR_OPCODE, {16'h0000, op});
    while (busy === 1'b1) @(posedge clk);
    n_checks++;
    if (blen < min) begin
      error_cnt++;
      $display("CHECK FAILED busy length expected %0d seen %0d", min, blen);
    end
  endtask
  task automatic t_set_field_instruction;
    fset(1'b0, 1'b1, 5'h05);
    fset(1'b1, 1'b0, 5'h10);
    wb(1'b1, 8'h08, 32'h0000_0FFF);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk("field settings", 32'h0000_0425, q);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, q);
  endtask
  task automatic t_stores;
    fset(1'b0, 1'b0, 5'h05);
    wb(1'b1, ra(0), 32'hFFFF_FFF5);
    wb(1'b1, ra(1), 32'h0001_5528);
    poke(16'h1552, 16'h0000);
    run({bit_field_move_pkg::OPG_ST_INC, 1'b0, 4'h0, 1'b0, 4'h1}, 0);
    mchk(16'h1552, 16'h1500);
    rchk(1, 32'h0001_552D);
    // File B, field straddles two words over an alternating AAAA background
    wb(1'b1, ra(16), 32'hFFFF_FFFF);
    wb(1'b1, ra(17), 32'h0001_5528);
    poke(16'h1551, 16'hAAAA);
    poke(16'h1552, 16'hAAAA);
    run({bit_field_move_pkg::OPG_ST_DEC, 1'b1, 4'h0, 1'b1, 4'h1}, 0);
    mchk(16'h1551, 16'hFFAA);
    mchk(16'h1552, 16'hAAFF);
    rchk(17, 32'h0001_5518);
    rchk(1, 32'h0001_552D);
    fset(1'b0, 1'b0, 5'h00);
    wb(1'b1, ra(16), 32'h1234_5678);
    wb(1'b1, ra(17), 32'h0001_5520);
    run({bit_field_move_pkg::OPG_ST_DEC, 1'b0, 4'h0, 1'b1, 4'h1}, 8);
    mchk(16'h1550, 16'h5678);
    mchk(16'h1551, 16'h1234);
  endtask
  task automatic t_offset_abs;
    fset(1'b0, 1'b0, 5'h1F);
    wb(1'b1, ra(0), 32'hFFFF_FFFF);
    wb(1'b1, ra(1), 32'h0001_5540);
    wb(1'b1, bit_field_move_pkg::ADDR_EXT, 32'h0000_FFF0);
    poke(16'h1553, 16'h0000);
    poke(16'h1554, 16'h0000);
    slow <= 1'b1;
    run({bit_field_move_pkg::OPG_ST_OFF, 1'b0, 4'h0, 1'b0, 4'h1}, 0);
    slow <= 1'b0;
    mchk(16'h1553, 16'hFFFF);
    mchk(16'h1554, 16'h7FFF);
    rchk(1, 32'h0001_5540);
    wb(1'b1, bit_field_move_pkg::ADDR_EXT, 32'h0001_550B);
    poke(16'h1550, 16'h0000);
    poke(16'h1551, 16'h0000);
    run(16'h0780, 0);
    mchk(16'h1550, 16'hF800);
    mchk(16'h1551, 16'h07FF);
    rchk(0, 32'hFFFF_FFFF);
  endtask
  task automatic t_load;
    logic [4:0]  sz [4] = '{5'h05, 5'h12, 5'h01, 5'h00};
    logic [31:0] ev [4] = '{32'hFFFF_FFF0, 32'h0003_7770, 32'h0000_0000, 32'h7777_7770};
    logic [31:0] fl [4] = '{32'hC000_0000, 32'h4000_0000, 32'h6000_0000, 32'h4000_0000};
    poke(16'h1550, 16'h7770);
    poke(16'h1551, 16'h7777);
    wb(1'b1, ra(0), 32'h0001_5500);
    wb(1'b1, bit_field_move_pkg::ADDR_STATUS, 32'h4000_0000);
    for (int i = 0; i < 4; i++) begin
      fset(!i[0], !i[0], sz[i]);
      run({bit_field_move_pkg::OPG_LD_IND, !i[0], 4'h0, 1'b0, 4'h1}, i == 3 ? 8 : 0);
      rchk(1, ev[i]);
      wb(1'b0, bit_field_move_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("flags", fl[i], q & 32'hF000_0000);
    end
  endtask
  task automatic t_memmem;
    poke(16'h1550, 16'h1234);
    poke(16'h1551, 16'h5678);
    wb(1'b1, ra(1), 32'h0001_5530);
    run({bit_field_move_pkg::OPG_MM_IND, 1'b0, 4'h0, 1'b0, 4'h1}, 11);
    mchk(16'h1553, 16'h1234);
    mchk(16'h1554, 16'h5678);
    rchk(0, 32'h0001_5500);
    run(16'h8020, 0);
    mchk(16'h1550, 16'h5530);
    wb(1'b1, 8'h00, 32'h0000_FFFF);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("illegal", 32'h0000_0002, q & 32'h0000_0002);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_set_field_instruction();
    t_stores();
    t_offset_abs();
    t_load();
    t_memmem();
    wrap_up();
  end
endmodule
`default_nettype wire
